// >>> shared/bxr_pkg.sv
// Constants shared by the bank extend and request logic.
`default_nettype none
package bxr_pkg;
  localparam logic [2:0] COMMON_BANK    = 3'h4;  // Bank 100.
  localparam logic [2:0] COUNT_NEXT     = 3'h7;  // Switch on the next cycle.
  localparam logic [2:0] COUNT_ONE      = 3'h3;  // One extra cycle.
  localparam logic [2:0] COUNT_TWO      = 3'h1;  // Two extra cycles.
  localparam logic [2:0] COUNT_THREE    = 3'h0;  // Three extra cycles.
  localparam logic [2:0] RESET_MODE_BANK = 3'h0;
  localparam logic [2:0] RESET_OVR_BANK  = 3'h0;
  localparam int unsigned MODE_D_BANK1  = 2;     // Data bit to bank bit 1.
  localparam int unsigned MODE_D_BANK0  = 3;     // Data bit to bank bit 0.
  localparam int unsigned MODE_D_BANK2  = 7;     // Data bit to bank bit 2.
  localparam logic [7:0] MODE_PORT      = 8'h80; // Fixed mode latch port.
  // Ready state machine, Gray coded along the usual path.
  typedef enum logic [1:0] {
    BXR_RDY_IDLE  = 2'b00,
    BXR_RDY_ARMED = 2'b01,
    BXR_RDY_WAIT1 = 2'b11,
    BXR_RDY_WAIT2 = 2'b10
  } bxr_rdy_e;
endpackage : bxr_pkg
`default_nettype wire

// >>> hw/bxr_op_decode.sv
// Opcode decoder: stack classification and initial cycle count.
`timescale 1ns/1ps
`default_nettype none
module bxr_op_decode (
  input  wire logic [7:0] opcode,
  output logic            is_stack,
  output logic [2:0]      init_count
);
  // Classify stack opcodes and give the extra cycles before the bank switch.
  always_comb begin
    is_stack   = 1'b0;
    init_count = bxr_pkg::COUNT_NEXT;
    casez (opcode)
      8'hcd, 8'b11???100: begin  // Call and conditional call.
        is_stack   = 1'b1;
        init_count = bxr_pkg::COUNT_TWO;
      end
      8'hc9, 8'b11???000, 8'b11??0001: begin  // Return and pop.
        is_stack   = 1'b1;
        init_count = bxr_pkg::COUNT_NEXT;
      end
      8'b11??0101, 8'b11???111: begin  // Push and restart.
        is_stack   = 1'b1;
        init_count = bxr_pkg::COUNT_ONE;
      end
      8'he3: begin  // Exchange with stack top.
        is_stack   = 1'b1;
        init_count = bxr_pkg::COUNT_NEXT;
      end
      default: begin
        is_stack   = 1'b0;
        init_count = bxr_pkg::COUNT_NEXT;
      end
    endcase
  end
endmodule : bxr_op_decode
`default_nettype wire

// >>> hw/bxr_top.sv
// Bank extend, request and ready logic of the processor module.
//
// The implementer's own choices: the placing of the registers and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - Decoder reads the data bus only in opcode fetch cycles.
// - Stack opcode loads the cycle counter as the fetch strobe ends.
// - Codes 111, 011, 001, 000 mean zero to three extra cycles.
// - Expired count selects common bank 100 through the default driver.
// - Common bank holds until next opcode fetch, which clears the counter.
// - Accesses at or above 48K use bank 100 while default driver enabled.
// - After override port write, override register drives bank lines instead.
// - Override write with address bit 14 high captures data bits 2 to 0.
// - Override write with address bit 14 low captures address bits 2 to 0.
// - Override write sets pending flag; next fetch arms flop and loads 111 into counter.
// - Armed and expired select override; next fetch clears both.
// - Ready low holds processor in wait until ready returns high.
// - Address and write data stay stable while request is asserted.
// - Wait comes from external line or module; at least one always.
// - Latch strobe sets flop, T1 edge drops ready, T3 restores it.
// - Slow ROM strap or loader active adds a second wait state.
// - Strobe low asserts request at T2; strobe high releases it.
// - Mode latch data bits 2,3,7 give bank bits 1,0,2.
// - Override applies only to the next instruction's memory access.
module bxr_top (
  input  wire logic        mclk,
  input  wire logic        rst_n,
  input  wire logic        clk_en,
  input  wire logic [7:0]  proc_data,
  input  wire logic [15:0] proc_addr,
  input  wire logic        cycle_status_0,
  input  wire logic        cycle_status_1,
  input  wire logic        addr_latch_en,
  input  wire logic        rd_n,
  input  wire logic        wr_n,
  input  wire logic        io_cycle,
  input  wire logic        ext_wait_n,
  input  wire logic        slow_rom_strap,
  input  wire logic        loader_rom_active,
  output logic             bank_bit_0,
  output logic             bank_bit_1,
  output logic             bank_bit_2,
  output logic             ready,
  output logic             bus_req_n,
  output logic [15:0]      bus_addr,
  output logic [7:0]       bus_wdata,
  output logic             memory_cycle_n
);
  logic [1:0]  rst_sync;
  logic        rst_q_n;
  logic [1:0]  wait_sync;
  logic [1:0]  strap_sync;
  logic [1:0]  loader_rom_active_sync;
  logic        ext_wait_q_n;
  logic        slow_q;
  logic        loader_rom_active_q;
  logic [2:0]  mode_bank;
  logic [2:0]  ovr_bank;
  logic [2:0]  count;
  logic        count_loaded;
  logic        armed;
  logic        op_stack_q;
  logic [2:0]  op_count_q;
  logic        strobe_end;
  logic        load_pending;
  logic        strobe_q;
  logic        t2_seen;
  logic [2:0]  next_bank;
  logic        is_stack;
  logic [2:0]  init_count;
  logic        opfetch;
  logic        expired;
  logic        upper_addr_bit14;
  logic        upper_addr_bit15;
  logic        strobe;
  logic        strobe_rise;
  logic        ovr_write;
  logic        mode_write;
  logic        two_waits;
  bxr_pkg::bxr_rdy_e rdy_state;
  bxr_pkg::bxr_rdy_e next_rdy_state;

  // Reset release passes two flops; assertion stays asynchronous.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rst_sync <= 2'h0;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end
  assign rst_q_n = rst_sync[1];

  // Pin inputs from outside the clock domain pass two flops.
  always_ff @(posedge mclk or negedge rst_q_n) begin
    if (!rst_q_n) begin
      wait_sync  <= 2'h3;
      strap_sync <= 2'h3;
      loader_rom_active_sync <= 2'h0;
    end else if (clk_en) begin
      wait_sync  <= {wait_sync[0], ext_wait_n};
      strap_sync <= {strap_sync[0], slow_rom_strap};
      loader_rom_active_sync <= {loader_rom_active_sync[0], loader_rom_active};
    end
  end
  assign ext_wait_q_n = wait_sync[1];
  assign slow_q       = ~strap_sync[1];
  assign loader_rom_active_q      = loader_rom_active_sync[1];

  // Cycle classification from processor status and strobes.
  assign opfetch          = cycle_status_0 & cycle_status_1;
  assign upper_addr_bit14 = proc_addr[14];
  assign upper_addr_bit15 = proc_addr[15];
  assign strobe           = ~(rd_n & wr_n);
  assign strobe_rise      = strobe & ~strobe_q;
  assign strobe_end       = ~strobe & strobe_q;
  assign ovr_write  = io_cycle & ~wr_n & strobe_rise & ~proc_addr[7];
  assign mode_write = io_cycle & ~wr_n & strobe_rise & (proc_addr[7:0] == bxr_pkg::MODE_PORT);
  assign expired    = count_loaded & (count == 3'h7);
  assign two_waits  = slow_q | loader_rom_active_q;

  // Opcode decoder sees the bus only when an opcode is fetched.
  bxr_op_decode u_dec (
    .opcode     (opfetch ? proc_data : 8'h00),
    .is_stack   (is_stack),
    .init_count (init_count)
  );

  // Opcode class is held from the fetch strobe start, since the bus is gone at its end.
  always_ff @(posedge mclk or negedge rst_q_n) begin
    if (!rst_q_n) begin
      op_stack_q <= 1'b0;
      op_count_q <= bxr_pkg::COUNT_NEXT;
    end else if (clk_en && opfetch && strobe_rise) begin
      op_stack_q <= is_stack;
      op_count_q <= init_count;
    end
  end

  // Strobe edge tracker.
  always_ff @(posedge mclk or negedge rst_q_n) begin
    if (!rst_q_n) begin
      strobe_q <= 1'b0;
    end else if (clk_en) begin
      strobe_q <= strobe;
    end
  end

  // Mode latch holds the default bank bits.
  always_ff @(posedge mclk or negedge rst_q_n) begin
    if (!rst_q_n) begin
      mode_bank <= bxr_pkg::RESET_MODE_BANK;
    end else if (clk_en && mode_write) begin
      mode_bank[1] <= proc_data[bxr_pkg::MODE_D_BANK1];
      mode_bank[0] <= proc_data[bxr_pkg::MODE_D_BANK0];
      mode_bank[2] <= proc_data[bxr_pkg::MODE_D_BANK2];
    end
  end

  // Override register captures accumulator or port byte bits.
  always_ff @(posedge mclk or negedge rst_q_n) begin
    if (!rst_q_n) begin
      ovr_bank <= bxr_pkg::RESET_OVR_BANK;
    end else if (clk_en && ovr_write) begin
      if (upper_addr_bit14) begin
        ovr_bank <= proc_data[2:0];
      end else begin
        ovr_bank <= proc_addr[2:0];
      end
    end
  end

  // Armed flop and pending counter load after an override write.
  always_ff @(posedge mclk or negedge rst_q_n) begin
    if (!rst_q_n) begin
      load_pending <= 1'b0;
      armed        <= 1'b0;
    end else if (clk_en) begin
      if (ovr_write) begin
        load_pending <= 1'b1;
      end else if (opfetch && strobe_end && load_pending) begin
        armed        <= 1'b1;
        load_pending <= 1'b0;
      end else if (opfetch && strobe_rise && !load_pending) begin
        armed <= 1'b0;
      end
    end
  end

  // Cycle counter: cleared as a fetch starts, loaded and stepped as cycles end.
  // A shift with a one in walks 000, 001, 011 to 111, one step per non-fetch cycle, I/O cycles included.
  always_ff @(posedge mclk or negedge rst_q_n) begin
    if (!rst_q_n) begin
      count        <= 3'h0;
      count_loaded <= 1'b0;
    end else if (clk_en && strobe_rise && opfetch) begin
      count_loaded <= 1'b0;
    end else if (clk_en && strobe_end) begin
      if (opfetch && load_pending) begin
        count        <= bxr_pkg::COUNT_NEXT;
        count_loaded <= 1'b1;
      end else if (opfetch && op_stack_q) begin
        count        <= op_count_q;
        count_loaded <= 1'b1;
      end else if (!opfetch && count_loaded && count != 3'h7) begin
        count <= {count[1:0], 1'b1};
      end
    end
  end

  // Bank multiplexer: override, common bank or mode latch.
  always_comb begin
    if (armed && expired) begin
      next_bank = ovr_bank;
    end else if (expired || (upper_addr_bit14 && upper_addr_bit15 && !armed)) begin
      next_bank = bxr_pkg::COMMON_BANK;
    end else begin
      next_bank = mode_bank;
    end
  end

  // Bank lines are registered each cycle.
  always_ff @(posedge mclk or negedge rst_q_n) begin
    if (!rst_q_n) begin
      bank_bit_0 <= bxr_pkg::RESET_MODE_BANK[0];
      bank_bit_1 <= bxr_pkg::RESET_MODE_BANK[1];
      bank_bit_2 <= bxr_pkg::RESET_MODE_BANK[2];
    end else if (clk_en) begin
      bank_bit_0 <= next_bank[0];
      bank_bit_1 <= next_bank[1];
      bank_bit_2 <= next_bank[2];
    end
  end

  // Ready state machine next state.
  always_comb begin
    case (rdy_state)
      bxr_pkg::BXR_RDY_IDLE: begin
        next_rdy_state = addr_latch_en ? bxr_pkg::BXR_RDY_ARMED : bxr_pkg::BXR_RDY_IDLE;
      end
      bxr_pkg::BXR_RDY_ARMED: begin
        next_rdy_state = bxr_pkg::BXR_RDY_WAIT1;
      end
      bxr_pkg::BXR_RDY_WAIT1: begin
        if (two_waits) begin
          next_rdy_state = bxr_pkg::BXR_RDY_WAIT2;
        end else if (ext_wait_q_n) begin
          next_rdy_state = bxr_pkg::BXR_RDY_IDLE;
        end else begin
          next_rdy_state = bxr_pkg::BXR_RDY_WAIT1;
        end
      end
      bxr_pkg::BXR_RDY_WAIT2: begin
        next_rdy_state = ext_wait_q_n ? bxr_pkg::BXR_RDY_IDLE : bxr_pkg::BXR_RDY_WAIT2;
      end
      default: begin
        next_rdy_state = bxr_pkg::BXR_RDY_IDLE;
      end
    endcase
  end

  // Ready state register and ready output.
  always_ff @(posedge mclk or negedge rst_q_n) begin
    if (!rst_q_n) begin
      rdy_state <= bxr_pkg::BXR_RDY_IDLE;
      ready     <= 1'b1;
    end else if (clk_en) begin
      rdy_state <= next_rdy_state;
      ready     <= (next_rdy_state != bxr_pkg::BXR_RDY_WAIT1) &&
                   (next_rdy_state != bxr_pkg::BXR_RDY_WAIT2);
    end
  end

  // Request asserts on the second edge after the strobe falls, ends with the strobe.
  always_ff @(posedge mclk or negedge rst_q_n) begin
    if (!rst_q_n) begin
      t2_seen   <= 1'b0;
      bus_req_n <= 1'b1;
    end else if (clk_en) begin
      t2_seen   <= strobe;
      bus_req_n <= ~(strobe & t2_seen);
    end
  end

  // Address and write data are frozen while the request stands.
  always_ff @(posedge mclk or negedge rst_q_n) begin
    if (!rst_q_n) begin
      bus_addr  <= 16'h0000;
      bus_wdata <= 8'h00;
    end else if (clk_en && bus_req_n) begin
      bus_addr  <= proc_addr;
      bus_wdata <= proc_data;
    end
  end

  // Memory cycle strobe for the counter clock, low during a memory access.
  always_ff @(posedge mclk or negedge rst_q_n) begin
    if (!rst_q_n) begin
      memory_cycle_n <= 1'b1;
    end else if (clk_en) begin
      memory_cycle_n <= ~(strobe & ~io_cycle);
    end
  end
endmodule : bxr_top
`default_nettype wire

// >>> sim/bxr_top_properties.sv
// Timing checker for the bank extend and request logic.
`timescale 1ns/1ps
`default_nettype none
module bxr_top_properties (
  input wire logic        mclk,
  input wire logic        rst_n,
  input wire logic        addr_latch_en,
  input wire logic        rd_n,
  input wire logic        wr_n,
  input wire logic        io_cycle,
  input wire logic        ext_wait_n,
  input wire logic        slow_rom_strap,
  input wire logic        loader_rom_active,
  input wire logic        ready,
  input wire logic        bus_req_n,
  input wire logic [15:0] bus_addr,
  input wire logic [7:0]  bus_wdata,
  input wire logic        memory_cycle_n
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  // High when neither strap nor loader asks for the longer wait.
  logic fast;
  assign fast = slow_rom_strap && !loader_rom_active;
  // Wait state length, request timing and bus stability.
  AST_READY_ONE: assert property (ext_wait_n[*3] ##0 (addr_latch_en && fast)
    |-> ##2 !ready ##1 ready) else $error("Single wait state wrong.");
  AST_READY_TWO: assert property (ext_wait_n[*3] ##0 (addr_latch_en && !fast)
    |-> ##2 (!ready)[*2] ##1 ready) else $error("Double wait state wrong.");
  AST_WAIT_HOLD: assert property (!ready && !ext_wait_n && $past(ext_wait_n) == 1'b0
    && $past(ext_wait_n, 2) == 1'b0 |=> !ready) else $error("Ready rose during wait.");
  AST_REQ_ASSERT: assert property ($fell(rd_n && wr_n) |-> ##2 !bus_req_n)
    else $error("Request not raised.");
  AST_REQ_RELEASE: assert property ($rose(rd_n && wr_n) |-> !bus_req_n ##1 bus_req_n)
    else $error("Request not released.");
  AST_REQ_IDLE: assert property ((rd_n && wr_n)[*3] |-> bus_req_n)
    else $error("Request without strobe.");
  AST_ADDR_STABLE: assert property (!bus_req_n && $past(bus_req_n) == 1'b0
    |-> $stable(bus_addr) && $stable(bus_wdata)) else $error("Bus moved in request.");
  AST_MEMORY_CYCLE_N_ON: assert property ((!rd_n && !io_cycle)[*2] |-> !memory_cycle_n)
    else $error("Memory cycle missing.");
  AST_MEMORY_CYCLE_N_OFF: assert property ((rd_n && wr_n)[*2] |-> memory_cycle_n)
    else $error("Memory cycle stuck.");
  COV_ONE: cover property (addr_latch_en && fast ##2 !ready);
  COV_TWO: cover property (addr_latch_en && !fast ##3 !ready);
  COV_EXT: cover property (!ext_wait_n && !ready);
endmodule : bxr_top_properties
bind bxr_top bxr_top_properties u_props (.mclk, .rst_n, .addr_latch_en, .rd_n, .wr_n,
  .io_cycle, .ext_wait_n, .slow_rom_strap, .loader_rom_active, .ready, .bus_req_n,
  .bus_addr, .bus_wdata, .memory_cycle_n);
`default_nettype wire

// >>> sim/bxr_cpu_model.sv
// Processor core and slow backplane module facing the bank logic.
`timescale 1ns/1ps
`default_nettype none
module bxr_cpu_model (
  input  wire logic       mclk,
  input  wire logic       ready,
  input  wire logic [3:0] ext_hold,
  output logic [7:0]      proc_data,
  output logic [15:0]     proc_addr,
  output logic            cycle_status_0,
  output logic            cycle_status_1,
  output logic            addr_latch_en,
  output logic            rd_n,
  output logic            wr_n,
  output logic            io_cycle,
  output logic            ext_wait_n
);
  // The bus starts idle with all strobes released.
  initial begin
    {proc_data, proc_addr} = 24'h0;
    {cycle_status_1, cycle_status_0, addr_latch_en, io_cycle} = 4'h0;
    {rd_n, wr_n, ext_wait_n} = 3'h7;
  end
  // One machine cycle; w counts the wait edges seen.
  task automatic cyc(input logic [1:0] st, input logic io, input logic wr,
                     input logic [15:0] a, input logic [7:0] d, output int w);
    w = 0;
    @(posedge mclk);
    {cycle_status_1, cycle_status_0, io_cycle, addr_latch_en} <= {st, io, 1'b1};
    {proc_addr, proc_data} <= {a, d};
    ext_wait_n <= (ext_hold == 4'h0);
    @(posedge mclk);
    addr_latch_en <= 1'b0;
    {rd_n, wr_n} <= {wr, !wr};
    // The strobe stays down until ready is seen high again.
    for (int k = 0; k < 20; k++) begin
      @(posedge mclk);
      if (k + 1 >= ext_hold) ext_wait_n <= 1'b1;
      if (ready === 1'b0) w++;
      else if (w > 0 && k >= 2) break;
    end
    {rd_n, wr_n, io_cycle} <= 3'h6;
    proc_data <= ~d; // A released bus no longer shows the old value.
  endtask : cyc
endmodule : bxr_cpu_model
`default_nettype wire

// >>> sim/bxr_top_bench.sv
// Self-checking bench for the bank extend and request logic.
`timescale 1ns/1ps
`default_nettype none
module bxr_top_bench;
  logic        mclk = 1'b0;
  logic        rst_n = 1'b0;
  logic        slow_rom_strap = 1'b1;
  logic        loader_rom_active = 1'b0;
  logic [3:0]  ext_hold = 4'h0;
  logic [7:0]  proc_data;
  logic [15:0] proc_addr, bus_addr;
  logic        cycle_status_0, cycle_status_1, addr_latch_en, rd_n, wr_n;
  logic        io_cycle, ext_wait_n, ready, bus_req_n, memory_cycle_n;
  logic        bank_bit_0, bank_bit_1, bank_bit_2;
  logic [7:0]  bus_wdata;
  int          err_count = 0;
  int          total_checks = 0;
  logic [7:0]  stk_op [3] = '{8'hc9, 8'hc5, 8'hcd};
  int          stk_pre [3] = '{0, 1, 2};
  // Free running system clock.
  always #5 mclk = ~mclk;
  bxr_cpu_model u_cpu (.mclk, .ready, .ext_hold, .proc_data, .proc_addr, .cycle_status_0,
    .cycle_status_1, .addr_latch_en, .rd_n, .wr_n, .io_cycle, .ext_wait_n);
  bxr_top dut (.mclk, .rst_n, .clk_en(1'b1), .proc_data, .proc_addr, .cycle_status_0,
    .cycle_status_1, .addr_latch_en, .rd_n, .wr_n, .io_cycle, .ext_wait_n,
    .slow_rom_strap, .loader_rom_active, .bank_bit_0, .bank_bit_1, .bank_bit_2, .ready,
    .bus_req_n, .bus_addr, .bus_wdata, .memory_cycle_n);
  // Compare and report one value.
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    total_checks++;
    if (g !== e) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // One machine cycle with checks on bank lines, request and waits.
  task automatic op(input logic [1:0] st, input logic io, input logic wr,
                    input logic [15:0] a, input logic [7:0] d, input logic [2:0] eb);
    int w;
    u_cpu.cyc(st, io, wr, a, d, w);
    if (!io) chk("bank", 16'(eb), 16'({bank_bit_2, bank_bit_1, bank_bit_0}));
    chk("bus_req_n", 16'h0, 16'(bus_req_n));
    chk("ready_end", 16'h1, 16'(ready));
    chk("bus_addr", a, bus_addr);
    chk("memory_cycle_n", 16'(io), 16'(memory_cycle_n));
    if (wr) chk("bus_wdata", 16'(d), 16'(bus_wdata));
    if (ext_hold != 4'h0) chk("long_wait", 16'h1, 16'(w > 3));
    else chk("waits", (slow_rom_strap && !loader_rom_active) ? 16'h1 : 16'h2, 16'(w));
  endtask : op
  task automatic fetch(input logic [7:0] o, input logic [2:0] eb);
    op(2'h3, 1'b0, 1'b0, 16'h0100, o, eb);
  endtask : fetch
  task automatic rd(input logic [15:0] a, input logic [2:0] eb);
    op(2'h2, 1'b0, 1'b0, a, 8'h5a, eb);
  endtask : rd
  task automatic outp(input logic [7:0] p, input logic [7:0] d);
    op(2'h1, 1'b1, 1'b1, {p, p}, d, 3'h0);
  endtask : outp
  task automatic do_reset;
    rst_n <= 1'b0;
    repeat (2) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (4) @(posedge mclk);
  endtask : do_reset
  task automatic give_verdict;
    if (err_count == 0 && total_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : give_verdict
  // Main sequence: mode latch, common bank, stack, overrides, waits.
  initial begin
    do_reset;
    fetch(8'h00, 3'h0);
    outp(8'h80, 8'h84);
    fetch(8'h00, 3'h6);
    rd(16'hf000, 3'h4);
    rd(16'hbfff, 3'h6);
    outp(8'h80, 8'h04);
    for (int i = 0; i < 3; i++) begin
      fetch(stk_op[i], 3'h2);
      for (int j = 0; j < stk_pre[i] + 2; j++) begin
        op(j < stk_pre[i] ? 2'h2 : 2'h1, 1'b0, j >= stk_pre[i], 16'h2000, 8'ha5,
           j < stk_pre[i] ? 3'h2 : 3'h4);
      end
    end
    fetch(8'h00, 3'h2);
    outp(8'h4f, 8'h07);
    fetch(8'h7e, 3'h2);
    rd(16'h3000, 3'h7);
    fetch(8'h00, 3'h2);
    rd(16'h3000, 3'h2);
    outp(8'h06, 8'hff);
    fetch(8'h7e, 3'h2);
    rd(16'hf000, 3'h6);
    fetch(8'h00, 3'h2);
    rd(16'hf000, 3'h4);
    outp(8'h06, 8'hff);
    do_reset;
    fetch(8'h00, 3'h0);
    rd(16'h3000, 3'h0);
    slow_rom_strap <= 1'b0;
    repeat (6) @(posedge mclk);
    rd(16'h3000, 3'h0);
    {slow_rom_strap, loader_rom_active} <= 2'h3;
    repeat (6) @(posedge mclk);
    rd(16'h3000, 3'h0);
    {loader_rom_active, ext_hold} <= {1'b0, 4'h6};
    repeat (6) @(posedge mclk);
    rd(16'h3000, 3'h0);
    give_verdict;
  end
endmodule : bxr_top_bench
`default_nettype wire
